/* ezc_capture.sv */
// Two-channel counter with zero-mark capture, write protection and gated measurement.
// Assumes an APB master on clk_in and asynchronous encoder pins needing synchronisers.
`include "ezc_regs.svh"

module ezc_capture
  import ezc_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Encoder pins per channel
  input wire logic [1:0] enc_a_in,
  input wire logic [1:0] enc_b_in,
  input wire logic [1:0] enc_zero_in,
  // Channel interrupt indications
  output logic [1:0] irq_out
);

  // ****************************************
  // Synchronisers
  // ****************************************
  // Two stages settle the pins; the third only marks edges for the detectors
  logic [1:0] a_s1_ff, a_s2_ff, a_s3_ff;
  logic [1:0] b_s1_ff, b_s2_ff, b_s3_ff;
  logic [1:0] z_s1_ff, z_s2_ff, z_s3_ff;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      a_s1_ff <= 2'h0;
      a_s2_ff <= 2'h0;
      a_s3_ff <= 2'h0;
      b_s1_ff <= 2'h0;
      b_s2_ff <= 2'h0;
      b_s3_ff <= 2'h0;
      z_s1_ff <= 2'h0;
      z_s2_ff <= 2'h0;
      z_s3_ff <= 2'h0;
    end else begin
      a_s1_ff <= enc_a_in;
      a_s2_ff <= a_s1_ff;
      a_s3_ff <= a_s2_ff;
      b_s1_ff <= enc_b_in;
      b_s2_ff <= b_s1_ff;
      b_s3_ff <= b_s2_ff;
      z_s1_ff <= enc_zero_in;
      z_s2_ff <= z_s1_ff;
      z_s3_ff <= z_s2_ff;
    end
  end

  // ****************************************
  // APB access decode
  // ****************************************
  // Writes land at the access edge; the answer is prepared at the setup edge
  logic wr_acc;
  assign wr_acc = psel_in && penable_in && pwrite_in;

  logic [31:0] ctrl0_ff, cfg_ff;
  logic [1:0] zm_enable_ff;
  logic [1:0] wp_ff, lock_ff, latch_ff;
  logic [1:0] ref_ff, hwf_ff, alarm_ff;
  logic [1:0] gate_open_ff;
  ezc_word_t cnt_ff [2];
  ezc_word_t cap_ff [2];
  ezc_word_t load_ff [2];

  logic cmd_wr;
  assign cmd_wr = wr_acc && (paddr_in == `EZC_ADDR_CMD);
  // Configuration registers take the whole word at once

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctrl0_ff <= 32'h0;
      cfg_ff <= 32'h0;
    end else if (wr_acc && paddr_in == `EZC_ADDR_CTRL0) begin
      ctrl0_ff <= pwdata_in;
    end else if (wr_acc && paddr_in == `EZC_ADDR_CFG) begin
      cfg_ff <= pwdata_in;
    end
  end

  // ****************************************
  // Internal counting clock enables
  // ****************************************
  localparam int DIV0 = `EZC_DIV(`EZC_F0_KHZ);
  localparam int DIV1 = `EZC_DIV(`EZC_F1_KHZ);
  localparam int DIV2 = `EZC_DIV(`EZC_F2_KHZ);
  localparam int DIV3 = `EZC_DIV(`EZC_F3_KHZ);
  // Free-running dividers; each tick is a one-cycle enable, never a clock
  logic [7:0] div_ff [4];
  logic [3:0] tick;

  genvar d;
  generate
    for (d = 0; d < 4; d++) begin : g_div
      localparam logic [7:0] LIM =
        8'((d == 0) ? DIV0 - 1 : (d == 1) ? DIV1 - 1 : (d == 2) ? DIV2 - 1 : DIV3 - 1);
      assign tick[d] = (div_ff[d] == LIM);
      always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
          div_ff[d] <= 8'h00;
        end else if (tick[d]) begin
          div_ff[d] <= 8'h00;
        end else begin
          div_ff[d] <= div_ff[d] + 8'h01;
        end
      end
    end
  endgenerate

  // ****************************************
  // Per-channel logic
  // ****************************************
  logic [1:0] ch_cyclic, ch_hw;
  assign ch_cyclic = {ctrl0_ff[`EZC_C0_CYCLIC1], ctrl0_ff[`EZC_C0_CYCLIC0]};
  assign ch_hw = {ctrl0_ff[`EZC_C0_HWSUP1], ctrl0_ff[`EZC_C0_HWSUP0]};

  genvar c;
  generate
    for (c = 0; c < 2; c++) begin : g_ch
      logic meas, int_tick, ext_tick, cnt_tick, zm_edge, zm_take;
      logic b_rise, gate_now;
      logic cmd_bit_strobe, cmd_bit_clear, cmd_bit_reload;
      logic host_cnt_wr, cnt_addr_hit;

      assign meas = cfg_ff[`EZC_CF_MEAS + c];
      assign zm_edge = z_s2_ff[c] && !z_s3_ff[c];
      assign b_rise = b_s2_ff[c] && !b_s3_ff[c];
      assign ext_tick = a_s2_ff[c] && !a_s3_ff[c];
      assign int_tick = ctrl0_ff[`EZC_C0_BOARD_MODE]
                      ? (cfg_ff[`EZC_CF_FSEL + c] ? tick[3] : tick[2])
                      : (cfg_ff[`EZC_CF_FSEL + c] ? tick[1] : tick[0]);
      // Frequency mode always counts A; pulse mode counts chosen source
      assign cnt_tick = (!cfg_ff[`EZC_CF_PULSE + c] || cfg_ff[`EZC_CF_EXTCLK + c])
                      ? ext_tick : int_tick;
      // Gate mode zero follows the level, mode one toggles on rising edges
      assign gate_now = cfg_ff[`EZC_CF_GATE_MODE + c] ? gate_open_ff[c] : b_s2_ff[c];

      // Lockout blocks only zero marks; the latch guards the unsupported mode
      assign zm_take = zm_edge && zm_enable_ff[c] && !wp_ff[c]
                     && !(ch_hw[c] && !ch_cyclic[c] && lock_ff[c])
                     && !(!ch_hw[c] && latch_ff[c]);

      assign cmd_bit_strobe = cmd_wr && pwdata_in[`EZC_CMD_SW_STROBE + c];
      assign cmd_bit_clear = cmd_wr && pwdata_in[`EZC_CMD_SW_CLEAR + c];
      assign cmd_bit_reload = cmd_wr && pwdata_in[`EZC_CMD_SW_RELOAD + c];
      assign cnt_addr_hit = (paddr_in == ((c == 0) ? `EZC_ADDR_CNT0 : `EZC_ADDR_CNT1));
      assign host_cnt_wr = wr_acc && cnt_addr_hit;
      // Edge mode toggles on each rising gate edge; level mode copies the pin

      always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
          gate_open_ff[c] <= 1'b0;
        end else if (cfg_ff[`EZC_CF_GATE_MODE + c]) begin
          if (b_rise) begin
            gate_open_ff[c] <= !gate_open_ff[c];
          end
        end else begin
          gate_open_ff[c] <= b_s2_ff[c];
        end
      end

      always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
          cnt_ff[c] <= 32'h0;
          // Protection beats every host write, clear and reload of the counter; reads still pass
        end else if (!wp_ff[c] && (host_cnt_wr || cmd_bit_clear || cmd_bit_reload)) begin
          if (host_cnt_wr) begin
            cnt_ff[c] <= pwdata_in;
          end else if (cmd_bit_clear) begin
            cnt_ff[c] <= 32'h0;
          end else begin
            cnt_ff[c] <= load_ff[c];
          end
        end else if (meas && gate_now && cnt_tick) begin
          cnt_ff[c] <= cnt_ff[c] + 32'h1;
        end else if (!meas && ext_tick) begin
          // Position counting reduced to single-edge evaluation of track A
          cnt_ff[c] <= b_s2_ff[c] ? cnt_ff[c] - 32'h1 : cnt_ff[c] + 32'h1;
        end
      end

      always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
          load_ff[c] <= 32'h0;
        end else if (wr_acc && paddr_in == ((c == 0) ? `EZC_ADDR_LOAD0 : `EZC_ADDR_LOAD1)) begin
          load_ff[c] <= pwdata_in;
        end
      end

      always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
          cap_ff[c] <= 32'h0;
        end else if (zm_take || (cmd_bit_strobe && !wp_ff[c])) begin
          // Strobe obeys protection; a zero mark was already checked in zm_take
          cap_ff[c] <= cnt_ff[c];
        end
      end

      always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
          wp_ff[c] <= 1'b0;
        end else if (zm_take && ch_hw[c]) begin
          // Set beats a same-cycle cancel so a capture is never left open
          wp_ff[c] <= 1'b1;
        end else if (cmd_wr && pwdata_in[`EZC_CMD_WP_CANCEL + c]) begin
          wp_ff[c] <= 1'b0;
        end
      end

      always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
          lock_ff[c] <= 1'b0;
        end else if (zm_take && ch_hw[c] && !ch_cyclic[c]) begin
          // Set beats the enable command so a simultaneous mark is not lost
          lock_ff[c] <= 1'b1;
        end else if (cmd_wr && pwdata_in[`EZC_CMD_ONCE_DIS]) begin
          lock_ff[c] <= 1'b1;
        end else if (cmd_wr && pwdata_in[`EZC_CMD_ONCE_EN + c]) begin
          lock_ff[c] <= 1'b0;
        end
      end

      always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
          latch_ff[c] <= 1'b0;
        end else if (zm_take && !ch_hw[c]) begin
          // Latch guards only the mode without hardware support, in position and measurement counting alike
          latch_ff[c] <= 1'b1;
        end else if (cmd_wr && pwdata_in[`EZC_CMD_ZM_LATCH_RST + c]) begin
          latch_ff[c] <= 1'b0;
        end
      end

      always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
          ref_ff[c] <= 1'b0;
          hwf_ff[c] <= 1'b0;
          alarm_ff[c] <= 1'b0;
        end else begin
          if (zm_take && !meas) begin
            // Reference and hardware flags stay set until reset
            ref_ff[c] <= 1'b1;
          end
          if (zm_take && ch_hw[c]) begin
            hwf_ff[c] <= 1'b1;
          end
          if (zm_take) begin
            alarm_ff[c] <= 1'b1;
          end else if (cmd_wr && pwdata_in[`EZC_CMD_ALARM_RST]) begin
            alarm_ff[c] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // Zero-mark inputs stay enabled until reset once commanded
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      zm_enable_ff <= 2'h0;
    end else if (cmd_wr && pwdata_in[`EZC_CMD_ZM_ENABLE]) begin
      zm_enable_ff <= 2'h3;
    end
  end

  // Interrupt indication follows the alarm flags
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      irq_out <= 2'h0;
    end else begin
      irq_out <= alarm_ff;
    end
  end

  // ****************************************
  // APB read data and answer
  // ****************************************
  logic [31:0] nxt_rdata;
  logic nxt_err;

  always_comb begin
    nxt_rdata = 32'h0;
    nxt_err = 1'b0;
    if (paddr_in == `EZC_ADDR_CTRL0) begin
      nxt_rdata = ctrl0_ff;
    end else if (paddr_in == `EZC_ADDR_STAT0) begin
      nxt_rdata[`EZC_S0_REF_SEEN_FLAG_CH0] = ref_ff[0];
      nxt_rdata[`EZC_S0_REF_SEEN_FLAG_CH1] = ref_ff[1];
      nxt_rdata[`EZC_S0_HW1] = hwf_ff[1];
      nxt_rdata[`EZC_S0_HW0] = hwf_ff[0];
    end else if (paddr_in == `EZC_ADDR_STAT1) begin
      nxt_rdata[`EZC_S1_ALARM0] = alarm_ff[0];
      nxt_rdata[`EZC_S1_ALARM1] = alarm_ff[1];
      nxt_rdata[`EZC_S1_GATE0] = gate_open_ff[0];
    end else if (paddr_in == `EZC_ADDR_STAT2) begin
      nxt_rdata[`EZC_S2_GATE1] = gate_open_ff[1];
    end else if (paddr_in == `EZC_ADDR_CMD) begin
      nxt_rdata = {24'h0, lock_ff, latch_ff, wp_ff, zm_enable_ff};
    end else if (paddr_in == `EZC_ADDR_CFG) begin
      nxt_rdata = cfg_ff;
    end else if (paddr_in == `EZC_ADDR_CNT0) begin
      nxt_rdata = cnt_ff[0];
    end else if (paddr_in == `EZC_ADDR_CNT1) begin
      nxt_rdata = cnt_ff[1];
    end else if (paddr_in == `EZC_ADDR_CAP0) begin
      nxt_rdata = cap_ff[0];
    end else if (paddr_in == `EZC_ADDR_CAP1) begin
      nxt_rdata = cap_ff[1];
    end else if (paddr_in == `EZC_ADDR_LOAD0) begin
      nxt_rdata = load_ff[0];
    end else if (paddr_in == `EZC_ADDR_LOAD1) begin
      nxt_rdata = load_ff[1];
    end else begin
      // Unmapped offsets answer with an error and zero data
      nxt_err = 1'b1;
    end
  end

  // Answer is registered: pready rises in the first access cycle
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h0;
    end else if (psel_in && !penable_in) begin
      pready_out <= 1'b1;
      pslverr_out <= nxt_err;
      prdata_out <= pwrite_in ? 32'h0 : nxt_rdata;
    end else begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      // Read data stands only with pready so a stale word never lingers
      prdata_out <= 32'h0;
    end
  end

endmodule

/* ezc_capture_monitor.sv */
// Concurrent checks on the ports of ezc_capture.
// Assumes it is bound to ezc_capture and sees only its ports.
`include "ezc_regs.svh"
module ezc_capture_monitor
  import ezc_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // APB
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  // Pins
  input wire logic [1:0] enc_zero_in,
  input wire logic [1:0] irq_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  logic [7:0] zero_hist_ff;
  logic [3:0] arst_hist_ff;
  logic alarm_rst;
  assign alarm_rst = psel_in && penable_in && pwrite_in && paddr_in == `EZC_ADDR_CMD
    && pwdata_in[`EZC_CMD_ALARM_RST];
  // ****
  // Recent zero-mark and alarm-reset history
  // ****
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      zero_hist_ff <= 8'h00;
      arst_hist_ff <= 4'h0;
    end else begin
      zero_hist_ff <= {zero_hist_ff[6:0], enc_zero_in[0]};
      arst_hist_ff <= {arst_hist_ff[2:0], alarm_rst};
    end
  end
  a_ready_after_setup: assert property (psel_in && !penable_in |=> pready_out)
    else $error("pready missing after setup");
  a_ready_single_pulse: assert property (pready_out |=> !pready_out)
    else $error("pready longer than one cycle");
  a_ready_in_access: assert property (pready_out |-> psel_in && penable_in)
    else $error("pready outside access phase");
  a_rdata_idle_zero: assert property (!pready_out |-> prdata_out == 32'h0)
    else $error("read data not zero while idle");
  a_err_with_ready: assert property (pslverr_out |-> pready_out)
    else $error("pslverr without pready");
  a_err_unmapped_addr: assert property (psel_in && !penable_in
    && paddr_in > `EZC_ADDR_LOAD1 |=> pslverr_out)
    else $error("unmapped access not refused");
  a_no_err_mapped: assert property (psel_in && !penable_in && paddr_in <= `EZC_ADDR_LOAD1
    && paddr_in[1:0] == 2'b00 |=> !pslverr_out)
    else $error("mapped access refused");
  a_irq_from_zero: assert property ($rose(irq_out[0]) |-> |zero_hist_ff)
    else $error("interrupt without zero mark");
  a_irq_sticky_flag: assert property ($fell(irq_out[0]) |-> |arst_hist_ff)
    else $error("interrupt dropped without alarm reset");
endmodule

/* ezc_enc_model.sv */
// Behavioural two-channel incremental encoder with zero-mark track.
// Assumes the bench calls its tasks; pins change just after clk_in rises.
module ezc_enc_model (
  // Clock
  input wire logic clk_in,
  // Encoder pins
  output logic [1:0] enc_a_out,
  output logic [1:0] enc_b_out,
  output logic [1:0] enc_zero_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    enc_a_out = 2'b00;
    enc_b_out = 2'b00;
    enc_zero_out = 2'b00;
  end
  // Pulse held three cycles high and eight low so the synchroniser sees one edge
  task automatic zero_pulse(input int ch);
    @(posedge clk_in);
    enc_zero_out[ch] <= 1'b1;
    repeat (3) @(posedge clk_in);
    enc_zero_out[ch] <= 1'b0;
    repeat (8) @(posedge clk_in);
  endtask
  task automatic a_pulses(input int ch, input int n);
    repeat (n) begin
      repeat (2) @(posedge clk_in);
      enc_a_out[ch] <= 1'b1;
      repeat (2) @(posedge clk_in);
      enc_a_out[ch] <= 1'b0;
    end
  endtask
  task automatic set_b(input int ch, input logic v);
    @(posedge clk_in);
    enc_b_out[ch] <= v;
  endtask
endmodule

/* ezc_pkg.sv */
// Types shared by the zero-mark capture block.
// Assumes ezc_regs.svh carries the numeric constants.
package ezc_pkg;
  typedef logic [31:0] ezc_word_t;
  typedef enum logic [1:0] {
    EZC_GATE_SHUT = 2'b00,
    EZC_GATE_OPEN = 2'b01
  } ezc_gate_t;
endpackage

/* ezc_regs.svh */
// Register offsets, field positions and timing constants for the zero-mark capture block.
// Assumes a 32-bit APB slave with word-aligned registers, clocked at 100 MHz.
`ifndef EZC_REGS_SVH
`define EZC_REGS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define EZC_ADDR_CTRL0 12'h000
`define EZC_ADDR_STAT0 12'h004
`define EZC_ADDR_STAT1 12'h008
`define EZC_ADDR_STAT2 12'h00C
`define EZC_ADDR_CMD 12'h010
`define EZC_ADDR_CFG 12'h014
`define EZC_ADDR_CNT0 12'h018
`define EZC_ADDR_CNT1 12'h01C
`define EZC_ADDR_CAP0 12'h020
`define EZC_ADDR_CAP1 12'h024
`define EZC_ADDR_LOAD0 12'h028
`define EZC_ADDR_LOAD1 12'h02C

// ****************************************
// Control register 0 fields
// ****************************************
`define EZC_C0_CYCLIC1 1
`define EZC_C0_CYCLIC0 3
`define EZC_C0_BOARD_MODE 4
`define EZC_C0_HWSUP0 5
`define EZC_C0_HWSUP1 6

// ****************************************
// Status register fields
// ****************************************
`define EZC_S0_REF_SEEN_FLAG_CH0 0
`define EZC_S0_REF_SEEN_FLAG_CH1 1
`define EZC_S0_HW1 2
`define EZC_S0_HW0 3
`define EZC_S1_ALARM0 6
`define EZC_S1_ALARM1 7
`define EZC_S1_GATE0 0
`define EZC_S2_GATE1 0

// ****************************************
// Configuration register fields (per channel: base + channel)
// ****************************************
`define EZC_CF_MEAS 0
`define EZC_CF_PULSE 2
`define EZC_CF_EXTCLK 4
`define EZC_CF_FSEL 6
`define EZC_CF_GATE_MODE 8

// ****************************************
// Command register bits (per channel: base + channel, except shared EZC_CMD_ZM_ENABLE, EZC_CMD_ALARM_RST and EZC_CMD_ONCE_DIS)
// ****************************************
`define EZC_CMD_ZM_ENABLE 0
`define EZC_CMD_ZM_LATCH_RST 2
`define EZC_CMD_WP_CANCEL 4
`define EZC_CMD_ONCE_EN 6
`define EZC_CMD_SW_STROBE 8
`define EZC_CMD_SW_CLEAR 10
`define EZC_CMD_SW_RELOAD 12
`define EZC_CMD_ALARM_RST 14
`define EZC_CMD_ONCE_DIS 15

// ****************************************
// Internal counting clock
// ****************************************
`define EZC_CLK_MHZ 100
`define EZC_F0_KHZ 2500
`define EZC_F1_KHZ 1250
`define EZC_F2_KHZ 4000
`define EZC_F3_KHZ 2000
`define EZC_DIV(khz) ((`EZC_CLK_MHZ * 1000) / (khz))

`endif

/* tb_ezc_capture.sv */
// Self-checking bench for ezc_capture: APB host tasks and an encoder model.
// Assumes the one-cycle APB answer and offsets of ezc_regs.svh.
`include "ezc_regs.svh"
module tb_ezc_capture
  import ezc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  bit clk_in;
  logic resetn_in;
  logic psel_in;
  logic penable_in;
  logic pwrite_in;
  logic [11:0] paddr_in;
  logic [31:0] pwdata_in;
  logic [31:0] prdata_out;
  logic pready_out;
  logic pslverr_out;
  logic [1:0] enc_a, enc_b, enc_z, irq_out;
  int n_fail = 0;
  int n_compared = 0;
  always #5 clk_in = ~clk_in;
  ezc_enc_model enc (.clk_in(clk_in), .enc_a_out(enc_a), .enc_b_out(enc_b),
    .enc_zero_out(enc_z));
  ezc_capture uut (.clk_in(clk_in), .resetn_in(resetn_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .enc_a_in(enc_a), .enc_b_in(enc_b),
    .enc_zero_in(enc_z), .irq_out(irq_out));
  // ****
  // Host tasks
  // ****
  task automatic chk(input ezc_word_t got, input ezc_word_t exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input ezc_word_t d,
    output ezc_word_t q);
    @(posedge clk_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    do begin
      @(posedge clk_in);
    end while (pready_out !== 1'b1);
    q = prdata_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input ezc_word_t d);
    ezc_word_t q;
    apb(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [11:0] a, input ezc_word_t e, input ezc_word_t m = 32'hFFFFFFFF);
    ezc_word_t q;
    apb(1'b0, a, 32'h0, q);
    chk(q & m, e);
  endtask
  task automatic print_verdict();
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic do_reset();
    resetn_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    resetn_in <= 1'b1;
  endtask
  initial begin
    #300us;
    n_fail++;
    print_verdict();
  end
  // ****
  // Tests
  // ****
  initial begin
    int khz[4];
    int e;
    ezc_word_t q;
    khz = '{`EZC_F0_KHZ, `EZC_F1_KHZ, `EZC_F2_KHZ, `EZC_F3_KHZ};
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    pwrite_in <= 1'b0;
    paddr_in <= 12'h000;
    pwdata_in <= 32'h0;
    do_reset();
    rdc(`EZC_ADDR_CMD, 32'h0);
    rdc(12'h030, 32'h0);
    wr(`EZC_ADDR_CNT0, 32'h12345678);
    wr(`EZC_ADDR_CMD, 32'h11);
    wr(`EZC_ADDR_CTRL0, 32'h20);
    wr(`EZC_ADDR_CMD, 32'h40);
    enc.zero_pulse(0);
    rdc(`EZC_ADDR_CAP0, 32'h12345678);
    rdc(`EZC_ADDR_STAT0, 32'h9);
    rdc(`EZC_ADDR_STAT1, 32'h40);
    chk({30'h0, irq_out}, 32'h1);
    rdc(`EZC_ADDR_CMD, 32'h47);
    wr(`EZC_ADDR_CNT0, 32'hAAAA);
    wr(`EZC_ADDR_CMD, 32'h500);
    rdc(`EZC_ADDR_CNT0, 32'h12345678);
    rdc(`EZC_ADDR_CAP0, 32'h12345678);
    $display("test hardware support one-time done");
    wr(`EZC_ADDR_CMD, 32'h10);
    rdc(`EZC_ADDR_CMD, 32'h43);
    wr(`EZC_ADDR_CNT0, 32'h55);
    enc.zero_pulse(0);
    rdc(`EZC_ADDR_CAP0, 32'h12345678);
    wr(`EZC_ADDR_CMD, 32'h100);
    wr(`EZC_ADDR_CAP0, 32'h99);
    rdc(`EZC_ADDR_CAP0, 32'h55);
    wr(`EZC_ADDR_CMD, 32'h40);
    wr(`EZC_ADDR_CNT0, 32'h77);
    enc.zero_pulse(0);
    rdc(`EZC_ADDR_CAP0, 32'h77);
    wr(`EZC_ADDR_CMD, 32'h4000);
    repeat (4) @(posedge clk_in);
    chk({30'h0, irq_out}, 32'h0);
    rdc(`EZC_ADDR_STAT1, 32'h0);
    $display("test protection and lockout done");
    wr(`EZC_ADDR_CTRL0, 32'h62);
    wr(`EZC_ADDR_CMD, 32'h20);
    wr(`EZC_ADDR_CNT1, 32'h100);
    enc.zero_pulse(1);
    rdc(`EZC_ADDR_CAP1, 32'h100);
    rdc(`EZC_ADDR_STAT0, 32'hF);
    rdc(`EZC_ADDR_STAT1, 32'h80);
    chk({30'h0, irq_out}, 32'h2);
    rdc(`EZC_ADDR_CMD, 32'h08, 32'h88);
    wr(`EZC_ADDR_CMD, 32'h20);
    wr(`EZC_ADDR_CNT1, 32'h200);
    enc.zero_pulse(1);
    rdc(`EZC_ADDR_CAP1, 32'h200);
    $display("test cyclic done");
    do_reset();
    wr(`EZC_ADDR_CMD, 32'h1);
    wr(`EZC_ADDR_CNT1, 32'h300);
    enc.zero_pulse(1);
    rdc(`EZC_ADDR_CAP1, 32'h300);
    rdc(`EZC_ADDR_STAT0, 32'h2);
    rdc(`EZC_ADDR_CMD, 32'h23);
    wr(`EZC_ADDR_CNT1, 32'h301);
    wr(`EZC_ADDR_CMD, 32'h200);
    rdc(`EZC_ADDR_CAP1, 32'h301);
    wr(`EZC_ADDR_CNT1, 32'h302);
    enc.zero_pulse(1);
    rdc(`EZC_ADDR_CAP1, 32'h301);
    wr(`EZC_ADDR_CMD, 32'h8);
    enc.zero_pulse(1);
    rdc(`EZC_ADDR_CAP1, 32'h302);
    $display("test without hardware support done");
    wr(`EZC_ADDR_LOAD0, 32'h1234);
    wr(`EZC_ADDR_CMD, 32'h1000);
    rdc(`EZC_ADDR_CNT0, 32'h1234);
    rdc(`EZC_ADDR_LOAD0, 32'h1234);
    wr(`EZC_ADDR_CFG, 32'h1);
    wr(`EZC_ADDR_CNT0, 32'h0);
    enc.set_b(0, 1'b1);
    enc.a_pulses(0, 5);
    rdc(`EZC_ADDR_STAT1, 32'h1, 32'h1);
    enc.set_b(0, 1'b0);
    enc.a_pulses(0, 3);
    rdc(`EZC_ADDR_CNT0, 32'h5);
    rdc(`EZC_ADDR_STAT1, 32'h0, 32'h1);
    wr(`EZC_ADDR_CFG, 32'h101);
    for (int i = 0; i < 2; i++) begin
      enc.set_b(0, 1'b1);
      repeat (4) @(posedge clk_in);
      enc.set_b(0, 1'b0);
      repeat (6) @(posedge clk_in);
      rdc(`EZC_ADDR_STAT1, 32'(1 - i), 32'h1);
    end
    for (int i = 0; i < 4; i++) begin
      wr(`EZC_ADDR_CTRL0, 32'((i / 2) << `EZC_C0_BOARD_MODE));
      wr(`EZC_ADDR_CFG, 32'h5 | 32'((i % 2) << `EZC_CF_FSEL));
      wr(`EZC_ADDR_CNT0, 32'h0);
      enc.set_b(0, 1'b1);
      repeat (400) @(posedge clk_in);
      enc.set_b(0, 1'b0);
      repeat (4) @(posedge clk_in);
      apb(1'b0, `EZC_ADDR_CNT0, 32'h0, q);
      e = 400 * khz[i] / 100000;
      chk(32'(q >= e - 1 && q <= e + 1), 32'h1);
    end
    $display("test measurement done");
    wr(`EZC_ADDR_CFG, 32'h15);
    wr(`EZC_ADDR_CNT0, 32'h0);
    enc.set_b(0, 1'b1);
    enc.a_pulses(0, 3);
    enc.set_b(0, 1'b0);
    rdc(`EZC_ADDR_CNT0, 32'h3);
    wr(`EZC_ADDR_CFG, 32'h2);
    wr(`EZC_ADDR_CNT1, 32'h0);
    enc.set_b(1, 1'b1);
    enc.a_pulses(1, 4);
    rdc(`EZC_ADDR_STAT2, 32'h1, 32'h1);
    enc.set_b(1, 1'b0);
    enc.a_pulses(1, 2);
    rdc(`EZC_ADDR_CNT1, 32'h4);
    rdc(`EZC_ADDR_STAT2, 32'h0, 32'h1);
    $display("test external clock and channel one done");
    print_verdict();
  end
endmodule
bind ezc_capture ezc_capture_monitor mon (.clk_in(clk_in), .resetn_in(resetn_in),
  .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .enc_zero_in(enc_zero_in), .irq_out(irq_out));
